//--- logic/tcr_pkg.sv
`default_nettype none
package tcr_pkg;

  // ----------------------------------------
  // Register map (bus register addresses)
  // ----------------------------------------
  localparam logic [5:0]  TCR_CAP_ADDR        = 6'h08;
  localparam logic [5:0]  TCR_RESULT_ADDR     = 6'h09;

  // ----------------------------------------
  // Capabilities word fields
  // ----------------------------------------
  localparam logic [2:0]  TCR_CAP_RESOLUTION  = 3'h1;    // One step is 0.5 degC
  localparam logic [2:0]  TCR_CAP_BIT_COUNT   = 3'h1;    // Ten significant bits
  localparam logic        TCR_CAP_SIGNED      = 1'h1;
  localparam logic        TCR_CAP_WIDTH_FLAG  = 1'h0;    // Sixteen-bit readout
  localparam logic        TCR_CAP_INTERNAL    = 1'h1;
  localparam logic [2:0]  TCR_CAP_REMOTES     = 3'h2;
  localparam logic [3:0]  TCR_CAP_RESERVED    = 4'h0;
  localparam logic [15:0] TCR_CAP_VALUE       = 16'h0549;

  // ----------------------------------------
  // Result word layout
  // ----------------------------------------
  localparam int          TCR_TEMP_LSB        = 6;
  localparam int          TCR_TEMP_WIDTH      = 10;
  localparam int          TCR_INDEX_LSB       = 2;
  localparam int          TCR_ERROR_BIT       = 1;
  localparam logic [9:0]  TCR_FAULT_CODE      = 10'h200; // Minus 256 degC
  localparam logic [15:0] TCR_RESULT_RESET    = 16'h0000;

  // ----------------------------------------
  // Sensors
  // ----------------------------------------
  localparam logic [1:0]  TCR_LOCAL_INDEX     = 2'h0;
  localparam logic [1:0]  TCR_SENSOR_COUNT    = 2'h3;

  // ----------------------------------------
  // Scan sequencer states, Gray coded
  // ----------------------------------------
  typedef enum logic [1:0] {
    TCR_SCAN_IDLE  = 2'b00,
    TCR_SCAN_START = 2'b01,
    TCR_SCAN_WAIT  = 2'b11
  } tcr_scan_state_type;

endpackage : tcr_pkg
`default_nettype wire

//--- logic/tcr_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tcr_conv_if;
  logic        start;
  logic [1:0]  sensor;
  logic        done;
  logic [9:0]  temp;
  logic        fault;
  logic        word_valid;
  logic [15:0] word;

  modport scan (output start, output sensor, input done);
  modport fmt  (input done, input temp, input fault, input sensor, output word_valid, output word);
  modport top  (input start, input sensor, output done, output temp, output fault,
                input word_valid, input word);
endinterface : tcr_conv_if
`default_nettype wire

//--- logic/tcr_scan.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_scan
  import tcr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Scan control
  input  wire logic       run_in,
  input  wire logic [2:0] sensor_enable_in,
  // Conversion side
  tcr_conv_if.scan        conv
);

  typedef struct packed {
    tcr_scan_state_type state;
    logic [1:0]         idx;
  } tcr_scan_reg_type;

  tcr_scan_reg_type r;
  tcr_scan_reg_type next_r;

  // First enabled sensor at or after from, wrapping; msb flags a hit
  function automatic logic [2:0] tcr_pick(input logic [1:0] from, input logic [2:0] en);
    logic [2:0] s;
    logic [2:0] res;
    res = 3'h0;
    for (int k = 2; k >= 0; k--) begin
      s = {1'b0, from} + 3'(k);
      if (s >= {1'b0, TCR_SENSOR_COUNT}) begin
        s = s - {1'b0, TCR_SENSOR_COUNT};
      end
      if (en[s[1:0]]) begin
        res = {1'b1, s[1:0]};
      end
    end
    return res;
  endfunction : tcr_pick

  // Next-state: ascending round robin, skipping disabled sensors
  always_comb begin
    logic [2:0] pick;
    pick   = tcr_pick(r.idx, sensor_enable_in);
    next_r = r;
    case (r.state)
      TCR_SCAN_IDLE: begin
        if (run_in && pick[2]) begin
          next_r.idx   = pick[1:0];
          next_r.state = TCR_SCAN_START;
        end
      end
      TCR_SCAN_START: begin
        next_r.state = TCR_SCAN_WAIT;
      end
      TCR_SCAN_WAIT: begin
        // Index held until done so the result is tagged with its own sensor
        if (conv.done) begin
          next_r.idx   = (r.idx == TCR_SENSOR_COUNT - 2'h1) ? 2'h0 : r.idx + 2'h1;
          next_r.state = TCR_SCAN_IDLE;
        end
      end
      default: begin
        next_r.state = TCR_SCAN_IDLE;
      end
    endcase
    if (!rst_b_in) begin
      next_r.state = TCR_SCAN_IDLE;
      next_r.idx   = TCR_LOCAL_INDEX;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    r <= next_r;
  end

  // Outputs
  assign conv.start  = (r.state == TCR_SCAN_START);
  assign conv.sensor = r.idx;

endmodule : tcr_scan
`default_nettype wire

//--- logic/tcr_format.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_format
  import tcr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // Conversion side
  tcr_conv_if.fmt   conv
);

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } tcr_fmt_reg_type;

  tcr_fmt_reg_type r;
  tcr_fmt_reg_type next_r;

  // Pack one conversion into a single word so all fields move together
  always_comb begin
    logic        remote_fault;
    remote_fault = conv.fault && (conv.sensor != TCR_LOCAL_INDEX);
    next_r       = r;
    next_r.valid = conv.done;
    if (conv.done) begin
      next_r.word = 16'h0000;
      next_r.word[TCR_TEMP_LSB +: TCR_TEMP_WIDTH] =
        remote_fault ? TCR_FAULT_CODE : conv.temp;
      next_r.word[TCR_INDEX_LSB +: 2] = conv.sensor;
      next_r.word[TCR_ERROR_BIT]      = remote_fault;
    end
    if (!rst_b_in) begin
      next_r.valid = 1'b0;
      next_r.word  = TCR_RESULT_RESET;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    r <= next_r;
  end

  assign conv.word_valid = r.valid;
  assign conv.word       = r.word;

endmodule : tcr_format
`default_nettype wire

//--- logic/tcr_temp_readout.sv
// Notes on behaviour
// - Capabilities bits 2-0 read 001, a half-degree step.
// - Capabilities bits 5-3 read 001, ten significant bits.
// - Capabilities bit 6 reads 1, signed two's complement data.
// - Capabilities bit 7 reads 0, sixteen-bit result register.
// - Capabilities bit 8 reads 1, on-die sensor present.
// - Capabilities bits 11-9 read 2, two remote sensors.
// - Capabilities is constant 0549h, top nibble zero, not writable.
// - Result bits 0 and 5-4 always read zero.
// - Error bit reads zero for local sensor results.
// - Error bit set for a faulted remote measurement, else clear.
// - A remote fault loads temperature code 200h.
// - Bits 3-2 carry the index of the sensor measured.
// - Index 0 is local, 1 and 2 are remotes.
// - Temperature sits left-justified in bits 15-6.
// - Reading the result clears new-result and overrun flags.
// - A result arriving unread overwrites and sets the overrun flag.
// - New-result flag sets on each store, holds until read.
// - Only enabled sensors are scanned, ascending, round robin.
`timescale 1ns/1ps
`default_nettype none
module tcr_temp_readout
  import tcr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Function control
  input  wire logic        function_enable_in,
  input  wire logic [2:0]  sensor_enable_in,
  // Converter handshake
  output logic             conv_start_out,
  output logic [1:0]       conv_sensor_out,
  input  wire logic        conv_done_in,
  input  wire logic [9:0]  conv_temp_in,
  input  wire logic        conv_fault_in,
  // Register read port from the bus engine
  input  wire logic        reg_rd_in,
  input  wire logic [5:0]  reg_addr_in,
  output logic [15:0]      rd_data_out,
  output logic             rd_valid_out,
  output logic             rd_unmapped_out,
  // Status towards the device status register
  output logic             temp_new_result_flag_out,
  output logic             temp_overrun_flag_out,
  output logic             function_event_out
);

  // ----------------------------------------
  // Internal carrier and submodules
  // ----------------------------------------
  tcr_conv_if conv ();

  assign conv.done  = conv_done_in;
  assign conv.temp  = conv_temp_in;
  assign conv.fault = conv_fault_in;

  tcr_scan u_scan (
    .clk_in           (clk_in),
    .rst_b_in         (rst_b_in),
    .run_in           (function_enable_in),
    .sensor_enable_in (sensor_enable_in),
    .conv             (conv.scan)
  );

  tcr_format u_format (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .conv     (conv.fmt)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] result;
    logic        new_flag;
    logic        overrun;
    logic        event_pulse;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        rd_unmapped;
  } tcr_top_reg_type;

  tcr_top_reg_type r;
  tcr_top_reg_type next_r;

  // Capabilities word assembled from its fields
  localparam logic [15:0] TCR_CAP_WORD = {TCR_CAP_RESERVED,
                                          TCR_CAP_REMOTES,
                                          TCR_CAP_INTERNAL,
                                          TCR_CAP_WIDTH_FLAG,
                                          TCR_CAP_SIGNED,
                                          TCR_CAP_BIT_COUNT,
                                          TCR_CAP_RESOLUTION};

  // Address match, shared by the read mux and the flag clear so both agree
  function automatic logic tcr_addr_hit(input logic [5:0] addr, input logic [5:0] reg_addr);
    return addr == reg_addr;
  endfunction : tcr_addr_hit

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // A store in the same cycle as a read wins: the read consumes the old
  // word, the new one arrives unread, so new_flag stays set and no overrun.
  always_comb begin
    logic rd_result;
    logic store;
    rd_result          = reg_rd_in && tcr_addr_hit(reg_addr_in, TCR_RESULT_ADDR);
    store              = conv.word_valid;
    next_r             = r;
    next_r.rd_valid    = reg_rd_in;
    next_r.rd_unmapped = 1'b0;
    next_r.event_pulse = store;
    // Read decode; the data returned is the word before any same-cycle store
    if (reg_rd_in) begin
      if (tcr_addr_hit(reg_addr_in, TCR_CAP_ADDR)) begin
        next_r.rd_data = TCR_CAP_WORD;
      end else if (tcr_addr_hit(reg_addr_in, TCR_RESULT_ADDR)) begin
        next_r.rd_data = r.result;
      end else begin
        next_r.rd_data     = 16'h0000;
        next_r.rd_unmapped = 1'b1;
      end
    end
    // Whole-word load keeps fields of one conversion together
    if (store) begin
      next_r.result = conv.word;
    end
    // Flags: clear on read, set wins over clear
    if (rd_result) begin
      next_r.new_flag = 1'b0;
      next_r.overrun  = 1'b0;
    end
    if (store) begin
      next_r.new_flag = 1'b1;
      if (r.new_flag && !rd_result) begin
        next_r.overrun = 1'b1;
      end
    end
    if (!rst_b_in) begin
      next_r = '0;
      next_r.result = TCR_RESULT_RESET;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    r <= next_r;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign conv_start_out           = conv.start;
  assign conv_sensor_out          = conv.sensor;
  assign rd_data_out              = r.rd_data;
  assign rd_valid_out             = r.rd_valid;
  assign rd_unmapped_out          = r.rd_unmapped;
  assign temp_new_result_flag_out = r.new_flag;
  assign temp_overrun_flag_out    = r.overrun;
  assign function_event_out       = r.event_pulse;

endmodule : tcr_temp_readout
`default_nettype wire

//--- tb/tcr_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_conv_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Start from the block and bench controls
  input  wire logic       start_in,
  input  wire logic       fault_in,
  input  wire logic [4:0] lat_in,
  input  wire logic [9:0] temp_in,
  // Result towards the block
  output logic            done_out,
  output logic            fault_out,
  output logic [9:0]      temp_out
);
  logic       busy;
  logic [4:0] cnt;
  // Idle result lines toggle so stale data is never taken as valid
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      busy <= 1'b0;
      cnt <= 5'h00;
      done_out <= 1'b0;
      fault_out <= 1'b0;
      temp_out <= 10'h000;
    end else begin
      done_out <= 1'b0;
      temp_out <= ~temp_out;
      fault_out <= ~fault_out;
      if (start_in) begin
        busy <= 1'b1;
        cnt <= lat_in;
      end else if (busy && cnt <= 5'h01) begin
        busy <= 1'b0;
        done_out <= 1'b1;
        temp_out <= temp_in;
        fault_out <= fault_in;
      end else if (busy) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule : tcr_conv_model
`default_nettype wire

//--- tb/tcr_temp_readout_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_temp_readout_asserts (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  // Converter handshake
  input wire logic        conv_start_out,
  input wire logic [1:0]  conv_sensor_out,
  input wire logic        conv_done_in,
  input wire logic [2:0]  sensor_enable_in,
  // Register read port
  input wire logic        reg_rd_in,
  input wire logic [5:0]  reg_addr_in,
  input wire logic        rd_valid_out,
  input wire logic [15:0] rd_data_out,
  // Status flags
  input wire logic        temp_new_result_flag_out,
  input wire logic        temp_overrun_flag_out,
  input wire logic        function_event_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Read of the result word
  wire logic rd_res = reg_rd_in && reg_addr_in == 6'h09;
  property p_rd_valid; reg_rd_in |=> rd_valid_out; endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  property p_cap; reg_rd_in && reg_addr_in == 6'h08 |=> rd_data_out == 16'h0549; endproperty
  a_cap: assert property (p_cap) else $error("capabilities word wrong");
  property p_resv; rd_res |=> rd_data_out[5:4] == 2'h0 && !rd_data_out[0]; endproperty
  a_resv: assert property (p_resv) else $error("reserved result bits set");
  property p_clear; rd_res |=> !temp_overrun_flag_out && (!temp_new_result_flag_out || function_event_out); endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared by read");
  property p_hold; temp_new_result_flag_out && !rd_res |=> temp_new_result_flag_out; endproperty
  a_hold: assert property (p_hold) else $error("new result flag dropped");
  property p_store; conv_done_in |-> ##2 function_event_out && temp_new_result_flag_out; endproperty
  a_store: assert property (p_store) else $error("result not stored");
  // Overrun flagged whenever an unread result is replaced
  property p_ovr; function_event_out && $past(temp_new_result_flag_out) && !$past(rd_res) |-> temp_overrun_flag_out;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  property p_scan; conv_start_out |-> sensor_enable_in[conv_sensor_out]; endproperty
  a_scan: assert property (p_scan) else $error("disabled sensor started");
  property p_index; conv_start_out |-> conv_sensor_out != 2'h3; endproperty
  a_index: assert property (p_index) else $error("sensor index out of range");
endmodule : tcr_temp_readout_asserts
bind tcr_temp_readout tcr_temp_readout_asserts tcr_temp_readout_asserts_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .conv_start_out(conv_start_out), .conv_done_in(conv_done_in), .reg_rd_in(reg_rd_in), .rd_valid_out(rd_valid_out),
  .temp_new_result_flag_out(temp_new_result_flag_out), .temp_overrun_flag_out(temp_overrun_flag_out),
  .function_event_out(function_event_out), .sensor_enable_in(sensor_enable_in),
  .conv_sensor_out(conv_sensor_out), .reg_addr_in(reg_addr_in), .rd_data_out(rd_data_out));
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_in, rst_b_in, function_enable_in, reg_rd_in, m_fault, conv_start_out, conv_done_in;
  logic        conv_fault_in, rd_valid_out, rd_unmapped_out, temp_new_result_flag_out;
  logic        temp_overrun_flag_out, function_event_out;
  logic [2:0]  sensor_enable_in;
  logic [1:0]  conv_sensor_out;
  logic [5:0]  reg_addr_in;
  logic [4:0]  m_lat;
  logic [9:0]  m_temp, conv_temp_in;
  logic [15:0] rd_data_out;
  int          num_errors = 0;
  int          checks_done = 0;
  tcr_temp_readout tcr_temp_readout_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .function_enable_in(function_enable_in),
    .sensor_enable_in(sensor_enable_in), .conv_start_out(conv_start_out), .conv_sensor_out(conv_sensor_out),
    .conv_done_in(conv_done_in), .conv_temp_in(conv_temp_in), .conv_fault_in(conv_fault_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .rd_unmapped_out(rd_unmapped_out), .temp_new_result_flag_out(temp_new_result_flag_out),
    .temp_overrun_flag_out(temp_overrun_flag_out), .function_event_out(function_event_out));
  tcr_conv_model tcr_conv_model_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(conv_start_out),
    .fault_in(m_fault), .lat_in(m_lat), .temp_in(m_temp), .done_out(conv_done_in), .fault_out(conv_fault_in),
    .temp_out(conv_temp_in));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // One register read, answer sampled a cycle after the request
  task automatic rd(input logic [5:0] a, input logic [15:0] exp, input bit cmp);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk("rd_valid", 16'h0001, {15'h0, rd_valid_out});
    chk("rd_unmapped", {15'h0, a != 6'h08 && a != 6'h09}, {15'h0, rd_unmapped_out});
    if (cmp) chk("rd_data", exp, rd_data_out);
  endtask : rd
  // Bounded wait for a stored result
  task automatic wait_evt;
    int n;
    for (n = 0; n < 300; n++) begin
      @(negedge clk_in);
      if (function_event_out === 1'b1) break;
    end
    if (n == 300) begin
      num_errors++;
      $display("mismatch result_wait expected event seen none");
      tally_and_finish();
    end
  endtask : wait_evt
  // Scan a sensor set; the drain lets an in-flight conversion land before the flush read
  task automatic run(input string nm, input logic [2:0] en, input logic [9:0] t, input logic f,
                     input logic [4:0] lat, input logic [15:0] exp, input bit two);
    @(posedge clk_in);
    sensor_enable_in <= en;
    m_temp <= t;
    m_fault <= f;
    m_lat <= lat;
    function_enable_in <= 1'b1;
    wait_evt();
    if (two) wait_evt();
    chk("new_flag", 16'h0001, {15'h0, temp_new_result_flag_out});
    chk("overrun_flag", {15'h0, two}, {15'h0, temp_overrun_flag_out});
    rd(6'h09, exp, 1'b1);
    chk("flags_after_read", 16'h0, {14'h0, temp_new_result_flag_out, temp_overrun_flag_out});
    @(posedge clk_in);
    function_enable_in <= 1'b0;
    repeat (40) @(posedge clk_in);
    rd(6'h09, 16'h0000, 1'b0);
    $display("test %s done", nm);
  endtask : run
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b_in = 1'b0;
    function_enable_in = 1'b0;
    sensor_enable_in = 3'h0;
    reg_rd_in = 1'b0;
    reg_addr_in = 6'h00;
    m_lat = 5'h04;
    m_temp = 10'h000;
    m_fault = 1'b0;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(6'h08, 16'h0549, 1'b1);
    rd(6'h0a, 16'h0000, 1'b1);
    $display("test registers done");
    run("remote_fault", 3'h4, 10'h155, 1'b1, 5'h04, 16'h800a, 1'b0);
    run("overrun", 3'h2, 10'h0c8, 1'b0, 5'h14, 16'h3204, 1'b1);
    run("order_local", 3'h5, 10'h3fe, 1'b1, 5'h14, 16'hff80, 1'b1);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
